// >>> src/ssai_core.sv
// spi unit: address match, hw select, preload, bit rate and irq enables
// ==========================================================
// Functional notes
// R1: scheme 0: compare address under second-value mask
// R2: scheme 1: accept either of two values
// R3: scheme 2: inclusive range, first is upper
// R4: hw select enable drives select as master
// R5: select fall wakes when detect enabled
// R6: early load of slave shifter when idle
// R7: data write with select high loads shifter
// R8: char width: code 0 eight, 1 nine
// R9: bit rate register, locked while enabled
// R10: clear register ones disable sources
// R11: set register ones enable sources
// R12: zeros leave enables unchanged
// R13: set and clear share enable bits
// R14: reads return current enable bits
// R15: enable bit positions fixed per source
// R16: select fell flag on slave select fall when detect enabled
// R17: rx done while unread, cleared by read
// R18: holding empty until new data written
// R19: error flag on overflow, write-one clears
// R20: irq when any enabled flag set
`timescale 1ns/1ps
`default_nettype none
module ssai_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWdata,
  input wire logic regLock,
  output logic [31:0] regRdata,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  input wire logic selNIn,
  output logic selNOut,
  output logic selNOe,
  output logic wake,
  output logic irq
);
  typedef struct packed {
    logic enable;
    logic [2:0] mode;
    logic [3:0] form;
    logic rxEn;
    logic [1:0] scheme;
    logic hwSel;
    logic wakeEn;
    logic earlyLoad;
    logic [2:0] charSel;
    logic [7:0] rate;
    logic [7:0] inten;
    logic errF;
    logic selF;
    logic txdF;
    logic rxFull;
    logic ovf;
    logic [7:0] matchVal;
    logic [7:0] secondVal;
    logic [8:0] txData;
    logic txFull;
    logic [8:0] rxData;
    logic [8:0] shift;
    logic [3:0] bitCnt;
    logic [7:0] divCnt;
    logic firstChar;
    logic matched;
    ssai_pkg::ssai_state_t state;
    logic sckPrev;
    logic selPrev;
    logic sck;
    logic sckEn;
    logic dOut;
    logic dOe;
    logic selOut;
    logic selOe;
    logic wakeP;
    logic irqL;
    logic [31:0] rdata;
  } ssai_regs_t;

  ssai_regs_t st_q;
  ssai_regs_t st_d;
  logic [2:0] pinF;

  ssai_sync3 #(.W(3), .RST_VAL(ssai_pkg::PIN_RST)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({sckIn, dataIn, selNIn}),
    .q(pinF)
  );

  // ==========================================================
  // helpers
  function automatic logic addrOk(input logic [1:0] sc, input logic [7:0] a,
                                  input logic [7:0] m, input logic [7:0] s);
    case (sc)
      // R1: masked compare
      ssai_pkg::SCHEME_MASK: addrOk = ((a ^ m) & ~s) == 8'h00;
      // R2: dual value
      ssai_pkg::SCHEME_DUAL: addrOk = (a == m) || (a == s);
      // R3: inclusive range
      ssai_pkg::SCHEME_RANGE: addrOk = (a <= m) && (a >= s);
      default: addrOk = 1'b0;
    endcase
  endfunction

  function automatic ssai_regs_t rxPush(input ssai_regs_t s, input logic [8:0] c);
    ssai_regs_t r;
    r = s;
    if (r.rxEn) begin
      // R19: overflow keeps old char, raises error
      if (r.rxFull) begin
        r.ovf = 1'b1;
        r.errF = 1'b1;
      end else begin
        r.rxData = c;
        r.rxFull = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] flagsOf(input ssai_regs_t s);
    logic [7:0] f;
    f = 8'h00;
    // R15: fixed source positions
    f[ssai_pkg::IRQ_ERR] = s.errF;
    f[ssai_pkg::IRQ_SEL] = s.selF;
    f[ssai_pkg::IRQ_RXD] = s.rxFull;
    f[ssai_pkg::IRQ_TXD] = s.txdF;
    f[ssai_pkg::IRQ_EMPTY] = !s.txFull;
    return f;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [3:0] nbits;
    logic [8:0] ch;
    logic sckRise;
    logic sckFall;
    logic selFall;
    logic selRise;
    logic isMaster;
    logic isSlave;
    logic nine;
    st_d = st_q;
    // R8: nine only for code 1, others eight
    nine = st_q.charSel == ssai_pkg::CHAR_NINE;
    nbits = nine ? ssai_pkg::BITS_NINE : ssai_pkg::BITS_EIGHT;
    ch = 9'h000;
    sckRise = pinF[2] && !st_q.sckPrev;
    sckFall = !pinF[2] && st_q.sckPrev;
    selFall = !pinF[0] && st_q.selPrev;
    selRise = pinF[0] && !st_q.selPrev;
    isMaster = st_q.enable && (st_q.mode == ssai_pkg::MODE_MASTER);
    isSlave = st_q.enable && (st_q.mode == ssai_pkg::MODE_SLAVE);
    st_d.sckPrev = pinF[2];
    st_d.selPrev = pinF[0];
    st_d.wakeP = 1'b0;
    // ==========================================================
    // register writes; clears come first so hardware sets win
    if (regWrite) begin
      case (regAddr)
        ssai_pkg::OFS_CTRLA: begin
          st_d.enable = regWdata[ssai_pkg::CA_ENABLE];
          if (!st_q.enable) begin
            st_d.mode = regWdata[ssai_pkg::CA_MODE_LSB +: 3];
            st_d.form = regWdata[ssai_pkg::CA_FORM_LSB +: 4];
          end
        end
        ssai_pkg::OFS_CTRLB: begin
          st_d.rxEn = regWdata[ssai_pkg::CB_RXEN];
          if (!st_q.enable) begin
            st_d.scheme = regWdata[ssai_pkg::CB_SCHEME_LSB +: 2];
            st_d.hwSel = regWdata[ssai_pkg::CB_HWSEL];
            st_d.wakeEn = regWdata[ssai_pkg::CB_WAKE];
            st_d.earlyLoad = regWdata[ssai_pkg::CB_EARLY];
            st_d.charSel = regWdata[ssai_pkg::CB_CHAR_LSB +: 3];
          end
        end
        ssai_pkg::OFS_RATE: begin
          // R9: only while disabled and unlocked
          if (!st_q.enable && !regLock) begin
            st_d.rate = regWdata[7:0];
          end
        end
        ssai_pkg::OFS_IEN_CLR: begin
          // R10: ones clear, R12: zeros keep
          if (!regLock) begin
            st_d.inten = st_q.inten & ~(regWdata[7:0] & ssai_pkg::IEN_IMPL);
          end
        end
        ssai_pkg::OFS_IEN_SET: begin
          // R11: ones set, R12: zeros keep
          if (!regLock) begin
            st_d.inten = st_q.inten | (regWdata[7:0] & ssai_pkg::IEN_IMPL);
          end
        end
        ssai_pkg::OFS_FLAGS: begin
          // R19: write one clears error
          if (regWdata[ssai_pkg::IRQ_ERR]) begin
            st_d.errF = 1'b0;
          end
          if (regWdata[ssai_pkg::IRQ_SEL]) begin
            st_d.selF = 1'b0;
          end
          if (regWdata[ssai_pkg::IRQ_TXD]) begin
            st_d.txdF = 1'b0;
          end
        end
        ssai_pkg::OFS_STATUS: begin
          if (regWdata[ssai_pkg::ST_OVF]) begin
            st_d.ovf = 1'b0;
          end
        end
        ssai_pkg::OFS_MATCH: begin
          if (!st_q.enable) begin
            st_d.matchVal = regWdata[7:0];
            st_d.secondVal = regWdata[ssai_pkg::MV_SECOND_LSB +: 8];
          end
        end
        ssai_pkg::OFS_DATA: begin
          // R18: new data fills the holding register, or the shifter on an early load
          st_d.txdF = 1'b0;
          // R6: early load when slave is idle
          // R7: select high moves data straight in
          if (isSlave && st_q.earlyLoad && pinF[0] && st_q.state == ssai_pkg::SSAI_IDLE) begin
            st_d.shift = regWdata[8:0];
            st_d.dOut = nine ? regWdata[8] : regWdata[7];
            st_d.txFull = 1'b0;
          end else begin
            st_d.txData = regWdata[8:0];
            st_d.txFull = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // R17: data read drains the receive buffer
    if (regRead && regAddr == ssai_pkg::OFS_DATA) begin
      st_d.rxFull = 1'b0;
    end
    // R17: disabled receiver flushes
    if (!st_d.rxEn) begin
      st_d.rxFull = 1'b0;
      st_d.ovf = 1'b0;
    end
    // ==========================================================
    // serial engine
    if (!st_q.enable) begin
      st_d.state = ssai_pkg::SSAI_IDLE;
      st_d.sck = 1'b0;
      st_d.selOut = 1'b1;
    end else if (isSlave) begin
      if (selFall) begin
        // R5: wake on select fall
        // R16: flag the fall
        if (st_q.wakeEn) begin
          st_d.wakeP = 1'b1;
          st_d.selF = 1'b1;
        end
        st_d.state = ssai_pkg::SSAI_SHIFT;
        st_d.bitCnt = 4'h0;
        st_d.firstChar = st_q.form == ssai_pkg::FORM_ADDR;
        st_d.matched = st_q.form != ssai_pkg::FORM_ADDR;
        if (st_d.txFull) begin
          st_d.shift = st_d.txData;
          st_d.txFull = 1'b0;
          st_d.dOut = nine ? st_d.txData[8] : st_d.txData[7];
        end
      end else if (selRise) begin
        // only a matched transaction completes
        if (st_q.matched && st_q.state != ssai_pkg::SSAI_IDLE) begin
          st_d.txdF = 1'b1;
        end
        st_d.state = ssai_pkg::SSAI_IDLE;
      end else if (st_q.state == ssai_pkg::SSAI_SHIFT && sckRise) begin
        st_d.shift = {st_q.shift[7:0], pinF[1]};
        st_d.bitCnt = st_q.bitCnt + 4'h1;
        if (st_d.bitCnt == nbits) begin
          st_d.bitCnt = 4'h0;
          ch = nine ? st_d.shift : {1'b0, st_d.shift[7:0]};
          st_d.firstChar = 1'b0;
          if (st_q.firstChar && !addrOk(st_q.scheme, ch[7:0], st_q.matchVal, st_q.secondVal)) begin
            st_d.state = ssai_pkg::SSAI_IGNORE;
          end else begin
            st_d.matched = 1'b1;
            st_d = rxPush(st_d, ch);
            if (st_d.txFull) begin
              st_d.shift = st_d.txData;
              st_d.txFull = 1'b0;
            end
          end
        end
      end else if (st_q.state == ssai_pkg::SSAI_SHIFT && sckFall) begin
        st_d.dOut = nine ? st_q.shift[8] : st_q.shift[7];
      end
    end else if (isMaster) begin
      if (st_q.state == ssai_pkg::SSAI_IDLE) begin
        st_d.sck = 1'b0;
        if (st_d.txFull) begin
          st_d.shift = st_d.txData;
          st_d.txFull = 1'b0;
          st_d.dOut = nine ? st_d.txData[8] : st_d.txData[7];
          st_d.state = ssai_pkg::SSAI_SHIFT;
          st_d.bitCnt = 4'h0;
          st_d.divCnt = 8'h00;
          // R4: select driven low for the transfer
          st_d.selOut = 1'b0;
        end else begin
          st_d.selOut = 1'b1;
        end
      end else if (st_q.divCnt != st_q.rate) begin
        // R9: rate sets the half-period length
        st_d.divCnt = st_q.divCnt + 8'h01;
      end else begin
        st_d.divCnt = 8'h00;
        st_d.sck = !st_q.sck;
        if (!st_q.sck) begin
          st_d.shift = {st_q.shift[7:0], dataIn_sampled(pinF)};
          st_d.bitCnt = st_q.bitCnt + 4'h1;
        end else if (st_q.bitCnt == nbits) begin
          ch = nine ? st_q.shift : {1'b0, st_q.shift[7:0]};
          st_d = rxPush(st_d, ch);
          st_d.bitCnt = 4'h0;
          if (st_d.txFull) begin
            st_d.shift = st_d.txData;
            st_d.txFull = 1'b0;
            st_d.dOut = nine ? st_d.txData[8] : st_d.txData[7];
          end else begin
            st_d.state = ssai_pkg::SSAI_IDLE;
            st_d.txdF = 1'b1;
            st_d.selOut = 1'b1;
          end
        end else begin
          st_d.dOut = nine ? st_q.shift[8] : st_q.shift[7];
        end
      end
    end
    st_d.sckEn = isMaster;
    st_d.dOe = isMaster || (isSlave && !pinF[0]);
    // R4: hardware select only when enabled
    st_d.selOe = isMaster && st_q.hwSel;
    // ==========================================================
    // read mux, answered one edge after the strobe
    if (regRead) begin
      case (regAddr)
        ssai_pkg::OFS_CTRLA: st_d.rdata = {4'h0, st_q.form, 16'h0000, 3'h0,
                                           st_q.mode, st_q.enable, 1'b0};
        ssai_pkg::OFS_CTRLB: st_d.rdata = {14'h0000, st_q.rxEn, 1'b0, st_q.scheme,
                                           st_q.hwSel, 3'h0, st_q.wakeEn, 2'h0,
                                           st_q.earlyLoad, 3'h0, st_q.charSel};
        ssai_pkg::OFS_RATE: st_d.rdata = {24'h000000, st_q.rate};
        // R13: both addresses show one enable set
        // R14: enabled sources read as one
        ssai_pkg::OFS_IEN_CLR: st_d.rdata = {24'h000000, st_q.inten};
        ssai_pkg::OFS_IEN_SET: st_d.rdata = {24'h000000, st_q.inten};
        ssai_pkg::OFS_FLAGS: st_d.rdata = {24'h000000, flagsOf(st_q)};
        ssai_pkg::OFS_STATUS: st_d.rdata = {29'h00000000, st_q.ovf, 2'h0};
        ssai_pkg::OFS_MATCH: st_d.rdata = {8'h00, st_q.secondVal, 8'h00, st_q.matchVal};
        ssai_pkg::OFS_DATA: st_d.rdata = {23'h000000, st_q.rxData};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
    // R20: any enabled flag raises the request
    st_d.irqL = |(flagsOf(st_d) & st_d.inten);
  end

  function automatic logic dataIn_sampled(input logic [2:0] p);
    return p[1];
  endfunction

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.rate <= ssai_pkg::RATE_RST;
      st_q.inten <= ssai_pkg::IEN_RST;
      st_q.state <= ssai_pkg::SSAI_IDLE;
      st_q.sckPrev <= 1'b0;
      st_q.selPrev <= 1'b1;
      st_q.selOut <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign sckOut = st_q.sck;
  assign sckOe = st_q.sckEn;
  assign dataOut = st_q.dOut;
  assign dataOe = st_q.dOe;
  assign selNOut = st_q.selOut;
  assign selNOe = st_q.selOe;
  assign wake = st_q.wakeP;
  assign irq = st_q.irqL;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clear_en;
    regWrite && regAddr == ssai_pkg::OFS_IEN_CLR && !regLock
      |=> (st_q.inten & $past(regWdata[7:0])) == 8'h00;
  endproperty
  a_clear_en: assert property (p_clear_en) else $error("enable not cleared"); // R10

  property p_set_en;
    regWrite && regAddr == ssai_pkg::OFS_IEN_SET && !regLock
      |=> (($past(regWdata[7:0]) & ssai_pkg::IEN_IMPL) & ~st_q.inten) == 8'h00;
  endproperty
  a_set_en: assert property (p_set_en) else $error("enable not set"); // R11

  property p_zero_keep;
    regWrite && regWdata[7:0] == 8'h00
      && (regAddr == ssai_pkg::OFS_IEN_SET || regAddr == ssai_pkg::OFS_IEN_CLR)
      |=> $stable(st_q.inten);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero write changed enable"); // R12

  property p_read_back;
    regRead && regAddr == ssai_pkg::OFS_IEN_CLR |=> regRdata[7:0] == $past(st_q.inten);
  endproperty
  a_read_back: assert property (p_read_back) else $error("enable readback wrong"); // R14

  property p_rate_lock;
    regWrite && regAddr == ssai_pkg::OFS_RATE && st_q.enable |=> $stable(st_q.rate);
  endproperty
  a_rate_lock: assert property (p_rate_lock) else $error("rate written while on"); // R9

  property p_wake;
    !pinF[0] && st_q.selPrev && st_q.enable && st_q.mode == ssai_pkg::MODE_SLAVE
      && st_q.wakeEn |=> wake && st_q.selF;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select fall"); // R5

  property p_no_wake;
    !st_q.wakeEn |=> !wake;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake while detector off"); // R5

  property p_preload;
    regWrite && regAddr == ssai_pkg::OFS_DATA && st_q.enable && st_q.earlyLoad
      && st_q.mode == ssai_pkg::MODE_SLAVE && pinF[0] && st_q.state == ssai_pkg::SSAI_IDLE
      |=> st_q.shift == $past(regWdata[8:0]) && !st_q.txFull;
  endproperty
  a_preload: assert property (p_preload) else $error("preload missed"); // R7

  property p_irq;
    irq == |(flagsOf(st_q) & st_q.inten);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // R20
endmodule
`default_nettype wire

// >>> src/ssai_pkg.sv
// shared constants and types for the spi address-match / irq-enable block
package ssai_pkg;
  // ==========================================================
  // register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_CTRLA = 8'h00;
  localparam logic [7:0] OFS_CTRLB = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h0c;
  localparam logic [7:0] OFS_IEN_CLR = 8'h14;
  localparam logic [7:0] OFS_IEN_SET = 8'h16;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1a;
  localparam logic [7:0] OFS_MATCH = 8'h24;
  localparam logic [7:0] OFS_DATA = 8'h28;
  // ==========================================================
  // field positions
  localparam int CA_ENABLE = 1;
  localparam int CA_MODE_LSB = 2;
  localparam int CA_FORM_LSB = 24;
  localparam int CB_CHAR_LSB = 0;
  localparam int CB_EARLY = 6;
  localparam int CB_WAKE = 9;
  localparam int CB_HWSEL = 13;
  localparam int CB_SCHEME_LSB = 14;
  localparam int CB_RXEN = 17;
  localparam int MV_SECOND_LSB = 16;
  localparam int ST_OVF = 2;
  localparam int IRQ_ERR = 7;
  localparam int IRQ_SEL = 3;
  localparam int IRQ_RXD = 2;
  localparam int IRQ_TXD = 1;
  localparam int IRQ_EMPTY = 0;
  localparam logic [7:0] IEN_IMPL = 8'h8f;
  // ==========================================================
  // codes
  localparam logic [2:0] MODE_SLAVE = 3'h2;
  localparam logic [2:0] MODE_MASTER = 3'h3;
  localparam logic [3:0] FORM_ADDR = 4'h2;
  localparam logic [1:0] SCHEME_MASK = 2'h0;
  localparam logic [1:0] SCHEME_DUAL = 2'h1;
  localparam logic [1:0] SCHEME_RANGE = 2'h2;
  localparam logic [2:0] CHAR_NINE = 3'h1;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // ==========================================================
  // reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [2:0] PIN_RST = 3'h1;
  typedef enum logic [2:0] {
    SSAI_IDLE = 3'b001,
    SSAI_SHIFT = 3'b010,
    SSAI_IGNORE = 3'b100
  } ssai_state_t;
endpackage

// >>> src/ssai_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ssai_sync3 #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // ==========================================================
  // stage one feeds stage two only; output moves when two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s2_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/ssai_master_model.sv
// spi master model driving the link pins of the block
`timescale 1ns/1ps
`default_nettype none
module ssai_master_model #(
  parameter int HALF = 40
) (
  output logic sck,
  output logic mosi,
  output logic selN,
  input wire logic miso,
  input wire logic misoOe
);
  // ==========================================================
  // idle: clock parked low, select high
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
  end
  // ==========================================================
  // frame control
  task automatic open_frame();
    selN = 1'b0;
    #(2 * HALF);
  endtask
  // released data line shows the inverse so a stale value never passes
  task automatic close_frame();
    #(HALF);
    selN = 1'b1;
    mosi = ~mosi;
    #(2 * HALF);
  endtask
  // mode 0, msb first: change while sck low, sample on rise
  task automatic shift(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF);
      sck = 1'b1;
      rx = {rx[7:0], misoOe ? miso : i[0]};
      #(HALF);
      sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_spi_slave_addr_and_irq_enable.sv
// self-checking bench for the spi address-match and irq-enable block
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_addr_and_irq_enable;
  logic clk, rst, regWrite, regRead, regLock;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic sckOut, sckOe, dataOut, dataOe, selNOut, selNOe, wake, irq;
  logic mSck, mMosi, mSel, sckLine, selLine;
  logic [8:0] rxv;
  int err_total, n_compared;
  int wakeCnt = 0;
  assign sckLine = sckOe ? sckOut : mSck;
  assign selLine = selNOe ? selNOut : mSel;
  ssai_core dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regLock(regLock), .regRdata(regRdata),
    .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe), .dataIn(mMosi), .dataOut(dataOut),
    .dataOe(dataOe), .selNIn(selLine), .selNOut(selNOut), .selNOe(selNOe), .wake(wake),
    .irq(irq));
  ssai_master_model mdl_u (.sck(mSck), .mosi(mMosi), .selN(mSel), .miso(dataOut),
    .misoOe(dataOe));
  // ==========================================================
  // clock and wake pulse counter
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wake === 1'b1) wakeCnt <= wakeCnt + 1;
  end
  // ==========================================================
  // shared tasks
  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    d = regRdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdv);
    chkv(rdv, e);
  endtask
  // control writes are ignored while enabled, so disable first
  task automatic setup(input logic [31:0] ca, input logic [31:0] cb, input logic [31:0] mv);
    wr(ssai_pkg::OFS_CTRLA, 32'h0);
    wr(ssai_pkg::OFS_CTRLB, cb);
    wr(ssai_pkg::OFS_MATCH, mv);
    wr(ssai_pkg::OFS_CTRLA, ca);
  endtask
  // sync latency of a few clocks is covered by the settle wait
  task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
    mdl_u.open_frame();
    mdl_u.shift(tx, n, rx);
    mdl_u.close_frame();
    repeat (10) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdchk(ssai_pkg::OFS_RATE, 32'h0);
    rdchk(ssai_pkg::OFS_IEN_SET, 32'h0);
    rdchk(ssai_pkg::OFS_IEN_CLR, 32'h0);
    rdchk(8'h3c, 32'h0);
  endtask
  task automatic t_enables();
    wr(ssai_pkg::OFS_IEN_SET, 32'hff);
    rdchk(ssai_pkg::OFS_IEN_CLR, 32'h8f);
    wr(ssai_pkg::OFS_IEN_CLR, 32'h05);
    rdchk(ssai_pkg::OFS_IEN_SET, 32'h8a);
    wr(ssai_pkg::OFS_IEN_SET, 32'h00);
    rdchk(ssai_pkg::OFS_IEN_CLR, 32'h8a);
    @(negedge clk);
    regLock = 1'b1;
    wr(ssai_pkg::OFS_IEN_SET, 32'hff);
    wr(ssai_pkg::OFS_RATE, 32'h11);
    rdchk(ssai_pkg::OFS_IEN_SET, 32'h8a);
    rdchk(ssai_pkg::OFS_RATE, 32'h0);
    @(negedge clk);
    regLock = 1'b0;
    wr(ssai_pkg::OFS_IEN_CLR, 32'hff);
    rdchk(ssai_pkg::OFS_IEN_SET, 32'h0);
  endtask
  task automatic t_rate();
    wr(ssai_pkg::OFS_RATE, 32'hffff_ff5a);
    rdchk(ssai_pkg::OFS_RATE, 32'h5a);
    wr(ssai_pkg::OFS_CTRLA, 32'h0a);
    wr(ssai_pkg::OFS_RATE, 32'h33);
    rdchk(ssai_pkg::OFS_RATE, 32'h5a);
  endtask
  task automatic t_slave();
    int n0;
    setup(32'h0a, 32'h0002_0240, 32'h0);
    wr(ssai_pkg::OFS_IEN_SET, 32'h08);
    wr(ssai_pkg::OFS_DATA, 32'ha5);
    n0 = wakeCnt;
    frame(9'h03c, 8, rxv);
    chkv({23'h0, rxv}, 32'ha5);
    chkv(wakeCnt, n0 + 1);
    rdchk(ssai_pkg::OFS_FLAGS, 32'h0f);
    chkv({31'h0, irq}, 32'h1);
    wr(ssai_pkg::OFS_FLAGS, 32'h08);
    @(negedge clk);
    chkv({31'h0, irq}, 32'h0);
    rdchk(ssai_pkg::OFS_DATA, 32'h3c);
    rdchk(ssai_pkg::OFS_FLAGS, 32'h03);
    mdl_u.open_frame();
    mdl_u.shift(9'h011, 8, rxv);
    mdl_u.shift(9'h022, 8, rxv);
    mdl_u.close_frame();
    repeat (10) @(negedge clk);
    rdchk(ssai_pkg::OFS_STATUS, 32'h04);
    rdchk(ssai_pkg::OFS_FLAGS, 32'h8f);
    rdchk(ssai_pkg::OFS_DATA, 32'h11);
    wr(ssai_pkg::OFS_FLAGS, 32'h80);
    rdchk(ssai_pkg::OFS_FLAGS, 32'h0b);
    wr(ssai_pkg::OFS_IEN_CLR, 32'hff);
  endtask
  task automatic t_nine();
    setup(32'h0a, 32'h0002_0001, 32'h0);
    frame(9'h1a5, 9, rxv);
    rdchk(ssai_pkg::OFS_DATA, 32'h1a5);
  endtask
  // table: hit, scheme, second value, first value, address byte
  task automatic t_match();
    logic [31:0] tab [8];
    logic [31:0] c;
    tab = '{32'h100f404a, 32'h100f404f, 32'h000f405a, 32'h11341234,
      32'h01341235, 32'h12103010, 32'h02103031, 32'h03103030};
    for (int i = 0; i < 8; i++) begin
      c = tab[i];
      // clear before the frame so a stale tx done cannot fake a hit
      wr(ssai_pkg::OFS_FLAGS, 32'h8a);
      setup(32'h0200000a, 32'h20000 | (32'(c[25:24]) << 14), {8'h0, c[23:16], 8'h0, c[15:8]});
      frame({1'b0, c[7:0]}, 8, rxv);
      rd(ssai_pkg::OFS_DATA, rdv);
      rd(ssai_pkg::OFS_FLAGS, rdv);
      chkv({31'h0, rdv[1]}, {31'h0, c[28]});
    end
  endtask
  task automatic t_hwsel();
    setup(32'h0e, 32'h2000, 32'h0);
    repeat (2) @(negedge clk);
    chkv({30'h0, selNOe, selNOut}, 32'h3);
    rdchk(ssai_pkg::OFS_STATUS, 32'h0);
    // one character at rate 0x5a: 16 halves of 91 clocks each
    wr(ssai_pkg::OFS_DATA, 32'h5a);
    repeat (1400) @(negedge clk);
    chkv({29'h0, sckOe, selNOe, selNOut}, 32'h6);
    repeat (200) @(negedge clk);
    chkv({29'h0, sckOe, selNOe, selNOut}, 32'h7);
    rdchk(ssai_pkg::OFS_FLAGS, 32'h03);
    setup(32'h0e, 32'h0, 32'h0);
    repeat (2) @(negedge clk);
    chkv({31'h0, selNOe}, 32'h0);
    wr(ssai_pkg::OFS_CTRLA, 32'h0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    err_total = 0;
    n_compared = 0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regLock = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_enables();
    t_rate();
    t_slave();
    t_nine();
    t_match();
    t_hwsel();
    conclude();
  end
  // about a dozen frames of some 0.9 us each plus a 7.3 us master transfer; generous margin
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
